//--- hw/isac_mem_ctrl.sv
// Memory-side end: interleaved instruction banks and simple data access
`timescale 1ns/10ps
`include "isac_cfg.svh"
module isac_mem_ctrl
    import isac_pkg::*;
#(
    parameter int CNT_W  = `ISAC_CNT_W,
    parameter int BANK_W = `ISAC_BANK_AW
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    isac_if.ctrl                   bus,
    output logic [BANK_W-1:0]      even_bank_addr,
    output logic [BANK_W-1:0]      odd_bank_addr,
    output logic                   even_bank_oe,
    output logic                   odd_bank_oe,
    input  wire logic [31:0]       even_bank_rdata,
    input  wire logic [31:0]       odd_bank_rdata,
    output logic [29:0]            data_mem_addr,
    output logic [3:0]             data_mem_we,
    output logic [31:0]            data_mem_wdata,
    input  wire logic [31:0]       data_mem_rdata,
    input  wire logic              coproc_present
);
    // ---------------- instruction side ----------------
    isac_istate_e          ist_reg,    ist_next;
    logic [CNT_W-1:0]      even_reg,   even_next;
    logic [CNT_W-1:0]      odd_reg,    odd_next;
    logic                  ibr_reg,    ibr_next;
    logic                  back_reg,   back_next;
    logic                  instr_ready_reg,   instr_ready_next;
    logic [31:0]           idata_reg,  idata_next;
    logic                  eoe_reg,    eoe_next;
    logic                  ooe_reg,    ooe_next;
    logic                  odd_first_reg, odd_first_next;
    logic                  instr_mem_access_cond;
    logic                  addr_load;
    logic                  even_cnt_en;

    assign instr_mem_access_cond = bus.instr_req;

    always_comb begin
        ist_next       = ist_reg;
        even_next      = even_reg;
        odd_next       = odd_reg;
        odd_first_next = odd_first_reg;
        back_next      = 1'b0;
        instr_ready_next      = 1'b0;
        addr_load      = 1'b0;
        even_cnt_en    = 1'b0;
        ibr_next       = bus.instr_burst_req;
        case (ist_reg)
            ISAC_I_IDLE: begin
                if (instr_mem_access_cond) begin
                    ist_next  = ISAC_I_WAIT;
                    addr_load = 1'b1;
                end
            end
            ISAC_I_WAIT: begin
                ist_next    = ISAC_I_START;
                even_cnt_en = odd_first_reg;
            end
            ISAC_I_START: begin
                instr_ready_next = 1'b1;
                if (ibr_reg) begin
                    ist_next    = ISAC_I_BURST;
                    back_next   = 1'b1;
                    even_cnt_en = 1'b1;
                end else begin
                    ist_next = ISAC_I_IDLE;
                end
            end
            ISAC_I_BURST: begin
                if (instr_mem_access_cond) begin
                    ist_next  = ISAC_I_WAIT;
                    addr_load = 1'b1;
                end else if (ibr_reg) begin
                    back_next   = 1'b1;
                    instr_ready_next   = 1'b1;
                    even_cnt_en = 1'b1;
                end
            end
            default: ist_next = ISAC_I_IDLE;
        endcase
        if (addr_load) begin
            // Word address bits 9..2 load both counters; A1..0 never used
            even_next      = bus.instr_addr[9:2];
            odd_next       = bus.instr_addr[9:2];
            odd_first_next = bus.instr_addr[2];
        end else begin
            if (even_cnt_en) begin
                even_next = even_reg + 1'b1;
            end
            // Odd low bit copies even low bit; carry into upper bits next cycle
            odd_next[0] = even_reg[0];
            if (odd_reg[0] && !even_reg[0]) begin
                odd_next[CNT_W-1:1] = odd_reg[CNT_W-1:1] + 1'b1;
            end
        end
    end

    always_comb begin
        eoe_next = 1'b0;
        ooe_next = 1'b0;
        if (ist_next == ISAC_I_START || ist_next == ISAC_I_BURST
            || (ist_reg == ISAC_I_START || ist_reg == ISAC_I_BURST) && instr_ready_next) begin
            // Low bit chooses the bank, so only one can be on
            // Odd start runs the even counter one word ahead, so flip the pick
            ooe_next = even_next[0] ^ odd_first_reg;
            eoe_next = ~(even_next[0] ^ odd_first_reg);
        end
    end

    always_comb begin
        idata_next = idata_reg;
        if (instr_ready_next) begin
            idata_next = eoe_reg ? even_bank_rdata : odd_bank_rdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ist_reg       <= ISAC_I_IDLE;
            even_reg      <= '0;
            odd_reg       <= '0;
            odd_first_reg <= 1'b0;
            ibr_reg       <= 1'b0;
            back_reg      <= 1'b0;
            instr_ready_reg      <= 1'b0;
            idata_reg     <= 32'h0000_0000;
            eoe_reg       <= 1'b0;
            ooe_reg       <= 1'b0;
        end else begin
            ist_reg       <= ist_next;
            even_reg      <= even_next;
            odd_reg       <= odd_next;
            odd_first_reg <= odd_first_next;
            ibr_reg       <= ibr_next;
            back_reg      <= back_next;
            instr_ready_reg      <= instr_ready_next;
            idata_reg     <= idata_next;
            eoe_reg       <= eoe_next;
            ooe_reg       <= ooe_next;
        end
    end

    assign bus.instr_burst_req_latched = ibr_reg;
    assign bus.instr_burst_ack         = back_reg;
    assign bus.instr_ready             = instr_ready_reg;
    assign bus.instr_data              = idata_reg;
    assign even_bank_addr              = even_reg[CNT_W-1:1];
    assign odd_bank_addr               = odd_reg[CNT_W-1:1];
    assign even_bank_oe                = eoe_reg;
    assign odd_bank_oe                 = ooe_reg;

    // ---------------- data side ----------------
    isac_dstate_e   dst_reg,   dst_next;
    logic [31:0]    daddr_reg, daddr_next;
    logic [2:0]     opt_reg,   opt_next;
    logic           dwr_reg,   dwr_next;
    logic [1:0]     spc_reg,   spc_next;
    logic [31:0]    wdat_reg,  wdat_next;
    logic           data_ready_reg,  data_ready_next;
    logic           data_error_reg,  data_error_next;
    logic [3:0]     we_reg,    we_next;
    logic [31:0]    rdat_reg,  rdat_next;
    logic [3:0]     lanes;

    always_comb begin
        // Option bits only meaningful with the request held
        case (opt_reg)
            `ISAC_OPT_BYTE: lanes = 4'h1 << daddr_reg[1:0];
            `ISAC_OPT_HALF: lanes = daddr_reg[1] ? 4'hC : 4'h3;
            default:        lanes = 4'hF;
        endcase
    end

    always_comb begin
        dst_next   = dst_reg;
        daddr_next = daddr_reg;
        opt_next   = opt_reg;
        dwr_next   = dwr_reg;
        spc_next   = spc_reg;
        wdat_next  = wdat_reg;
        data_ready_next  = 1'b0;
        data_error_next  = 1'b0;
        we_next    = 4'h0;
        rdat_next  = rdat_reg;
        case (dst_reg)
            ISAC_D_IDLE: begin
                if (bus.data_req && !bus.bus_invalid) begin
                    dst_next   = ISAC_D_START;
                    daddr_next = bus.data_addr;
                    opt_next   = bus.option_bits;
                    dwr_next   = bus.data_write;
                    spc_next   = {bus.data_space_type_hi, bus.data_space_type_lo};
                    wdat_next  = bus.data_wdata;
                end
            end
            ISAC_D_START: begin
                dst_next = ISAC_D_IDLE;
                if (spc_reg[1]) begin
                    // Coprocessor answers for itself; stay silent
                    data_ready_next = 1'b0;
                end else if (spc_reg != `ISAC_SPACE_MEM) begin
                    data_error_next = 1'b1;
                end else begin
                    data_ready_next = 1'b1;
                    we_next   = dwr_reg ? lanes : 4'h0;
                    rdat_next = data_mem_rdata;
                end
            end
            default: dst_next = ISAC_D_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dst_reg   <= ISAC_D_IDLE;
            daddr_reg <= 32'h0000_0000;
            opt_reg   <= `ISAC_OPT_WORD;
            dwr_reg   <= 1'b0;
            spc_reg   <= `ISAC_SPACE_MEM;
            wdat_reg  <= 32'h0000_0000;
            data_ready_reg  <= 1'b0;
            data_error_reg  <= 1'b0;
            we_reg    <= 4'h0;
            rdat_reg  <= 32'h0000_0000;
        end else begin
            dst_reg   <= dst_next;
            daddr_reg <= daddr_next;
            opt_reg   <= opt_next;
            dwr_reg   <= dwr_next;
            spc_reg   <= spc_next;
            wdat_reg  <= wdat_next;
            data_ready_reg  <= data_ready_next;
            data_error_reg  <= data_error_next;
            we_reg    <= we_next;
            rdat_reg  <= rdat_next;
        end
    end

    assign bus.data_ready  = data_ready_reg;
    assign bus.data_error  = data_error_reg;
    assign bus.data_rdata  = rdat_reg;
    assign data_mem_addr   = daddr_reg[31:2];
    assign data_mem_we     = we_reg;
    assign data_mem_wdata  = wdat_reg;
endmodule

//--- hw/isac_cfg.svh
// Constants for the interleaved SRAM access control block
// How it works
// - Low two address bits never reach memory
// - Bank address is counter's upper seven bits
// - A2 picks first bank enable, then alternate
// - Odd counter copies even low bit, lagged
// - First instruction access takes three cycles
// - Even counter is 8-bit, counts when enabled
// - Even counter low bit, flipped by A2, picks the bank enable
// - Idle to wait on access, pulse address load
// - Wait to start; start to idle without burst
// - Start with burst goes burst, acknowledges
// - New access in burst restarts via wait
// - Data request answered by two-state machine
// - Space type 00 mem, 01 io, 1x coproc
// - Error only for space type 01 (io)
// - Coprocessor space: no ready, no error
// - Partial reads return the full word
// - Byte store enables only addressed lane
// - Lane strobes from A1..0 and option bits
// - Options 000 word, 001 byte, 010 half
// - Bus invalid in first cycle holds idle
// - Start to idle gives ready and writes for space type 00 (mem)
`ifndef ISAC_CFG_SVH
`define ISAC_CFG_SVH
`define ISAC_ADDR_W     32
`define ISAC_CNT_W      8
`define ISAC_BANK_AW    7
`define ISAC_CNT_LSB    3
`define ISAC_OPT_WORD   3'h0
`define ISAC_OPT_BYTE   3'h1
`define ISAC_OPT_HALF   3'h2
`define ISAC_SPACE_MEM  2'h0
`define ISAC_SPACE_IO   2'h1
`endif

//--- hw/isac_pkg.sv
// Types shared by both ends of the access control block
package isac_pkg;
    typedef enum logic [3:0] {
        ISAC_I_IDLE  = 4'h1,
        ISAC_I_WAIT  = 4'h2,
        ISAC_I_START = 4'h4,
        ISAC_I_BURST = 4'h8
    } isac_istate_e;
    typedef enum logic [1:0] {
        ISAC_D_IDLE  = 2'h1,
        ISAC_D_START = 2'h2
    } isac_dstate_e;
endpackage

//--- hw/isac_if.sv
// Processor-side buses between the processor end and the memory controller
`timescale 1ns/10ps
interface isac_if;
    logic        instr_req;
    logic [31:0] instr_addr;
    logic        instr_burst_req;
    logic        instr_burst_req_latched;
    logic        instr_burst_ack;
    logic        instr_ready;
    logic [31:0] instr_data;
    logic        data_req;
    logic [31:0] data_addr;
    logic        data_space_type_lo;
    logic        data_space_type_hi;
    logic [2:0]  option_bits;
    logic        data_write;
    logic [31:0] data_wdata;
    logic        bus_invalid;
    logic        data_ready;
    logic        data_error;
    logic [31:0] data_rdata;
    modport ctrl (
        input  instr_req, instr_addr, instr_burst_req, data_req, data_addr,
               data_space_type_lo, data_space_type_hi, option_bits, data_write,
               data_wdata, bus_invalid,
        output instr_burst_req_latched, instr_burst_ack, instr_ready, instr_data,
               data_ready, data_error, data_rdata
    );
    modport proc (
        output instr_req, instr_addr, instr_burst_req, data_req, data_addr,
               data_space_type_lo, data_space_type_hi, option_bits, data_write,
               data_wdata, bus_invalid,
        input  instr_burst_req_latched, instr_burst_ack, instr_ready, instr_data,
               data_ready, data_error, data_rdata
    );
endinterface

//--- hw/isac_proc_end.sv
// Processor-side end: issues instruction fetches and simple data accesses
`timescale 1ns/10ps
`include "isac_cfg.svh"
module isac_proc_end
    import isac_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    isac_if.proc             bus,
    input  wire logic        fetch_start,
    input  wire logic [31:0] fetch_addr,
    input  wire logic        fetch_burst,
    output logic             fetch_valid,
    output logic [31:0]      fetch_data,
    input  wire logic        dreq_start,
    input  wire logic [31:0] dreq_addr,
    input  wire logic [1:0]  dreq_space,
    input  wire logic [2:0]  dreq_size,
    input  wire logic        dreq_write,
    input  wire logic [31:0] dreq_wdata,
    input  wire logic        dreq_invalid,
    output logic             dresp_valid,
    output logic             dresp_error,
    output logic [31:0]      dresp_rdata
);
    logic        ireq_reg,  ireq_next;
    logic [31:0] iaddr_reg, iaddr_next;
    logic        ibr_reg,   ibr_next;
    logic        fv_reg,    fv_next;
    logic [31:0] fd_reg,    fd_next;
    logic        dreq_reg,  dreq_next;
    logic [31:0] daddr_reg, daddr_next;
    logic [1:0]  dsp_reg,   dsp_next;
    logic [2:0]  dopt_reg,  dopt_next;
    logic        dwr_reg,   dwr_next;
    logic [31:0] dwd_reg,   dwd_next;
    logic        binv_reg,  binv_next;
    logic        dv_reg,    dv_next;
    logic        de_reg,    de_next;
    logic [31:0] drd_reg,   drd_next;

    always_comb begin
        ireq_next  = 1'b0;
        iaddr_next = iaddr_reg;
        ibr_next   = ibr_reg && fetch_burst;
        fv_next    = bus.instr_ready;
        fd_next    = bus.instr_ready ? bus.instr_data : fd_reg;
        if (fetch_start) begin
            // Burst request dropped before a new fetch, else raised with it
            // Raised late, the start state would miss it and end the burst
            ibr_next   = fetch_burst && !ibr_reg;
            ireq_next  = !ibr_reg;
            iaddr_next = fetch_addr;
        end else if (fetch_burst && !ireq_reg) begin
            ibr_next = 1'b1;
        end
        dreq_next  = 1'b0;
        binv_next  = 1'b0;
        daddr_next = daddr_reg;
        dsp_next   = dsp_reg;
        dopt_next  = dopt_reg;
        dwr_next   = dwr_reg;
        dwd_next   = dwd_reg;
        if (dreq_start) begin
            dreq_next  = 1'b1;
            binv_next  = dreq_invalid;
            daddr_next = dreq_addr;
            dsp_next   = dreq_space;
            dopt_next  = dreq_size;
            dwr_next   = dreq_write;
            // Byte and half stores copied to every lane
            case (dreq_size)
                `ISAC_OPT_BYTE: dwd_next = {4{dreq_wdata[7:0]}};
                `ISAC_OPT_HALF: dwd_next = {2{dreq_wdata[15:0]}};
                default:        dwd_next = dreq_wdata;
            endcase
        end
        dv_next  = bus.data_ready;
        de_next  = bus.data_error;
        drd_next = bus.data_ready ? bus.data_rdata : drd_reg;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ireq_reg  <= 1'b0;
            iaddr_reg <= 32'h0000_0000;
            ibr_reg   <= 1'b0;
            fv_reg    <= 1'b0;
            fd_reg    <= 32'h0000_0000;
            dreq_reg  <= 1'b0;
            daddr_reg <= 32'h0000_0000;
            dsp_reg   <= `ISAC_SPACE_MEM;
            dopt_reg  <= `ISAC_OPT_WORD;
            dwr_reg   <= 1'b0;
            dwd_reg   <= 32'h0000_0000;
            binv_reg  <= 1'b0;
            dv_reg    <= 1'b0;
            de_reg    <= 1'b0;
            drd_reg   <= 32'h0000_0000;
        end else begin
            ireq_reg  <= ireq_next;
            iaddr_reg <= iaddr_next;
            ibr_reg   <= ibr_next;
            fv_reg    <= fv_next;
            fd_reg    <= fd_next;
            dreq_reg  <= dreq_next;
            daddr_reg <= daddr_next;
            dsp_reg   <= dsp_next;
            dopt_reg  <= dopt_next;
            dwr_reg   <= dwr_next;
            dwd_reg   <= dwd_next;
            binv_reg  <= binv_next;
            dv_reg    <= dv_next;
            de_reg    <= de_next;
            drd_reg   <= drd_next;
        end
    end

    assign bus.instr_req          = ireq_reg;
    assign bus.instr_addr         = iaddr_reg;
    assign bus.instr_burst_req    = ibr_reg;
    assign bus.data_req           = dreq_reg;
    assign bus.data_addr          = daddr_reg;
    assign bus.data_space_type_lo = dsp_reg[0];
    assign bus.data_space_type_hi = dsp_reg[1];
    assign bus.option_bits        = dopt_reg;
    assign bus.data_write         = dwr_reg;
    assign bus.data_wdata         = dwd_reg;
    assign bus.bus_invalid        = binv_reg;
    assign fetch_valid            = fv_reg;
    assign fetch_data             = fd_reg;
    assign dresp_valid            = dv_reg;
    assign dresp_error            = de_reg;
    assign dresp_rdata            = drd_reg;
endmodule

//--- verification/isac_monitor.sv
// Checker watching the processor-side buses between the two ends
`timescale 1ns/10ps
module isac_monitor (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic instr_req,
    input wire logic instr_burst_req,
    input wire logic instr_burst_req_latched,
    input wire logic instr_burst_ack,
    input wire logic instr_ready,
    input wire logic data_req,
    input wire logic data_space_type_lo,
    input wire logic data_space_type_hi,
    input wire logic bus_invalid,
    input wire logic data_ready,
    input wire logic data_error
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // First edge after reset still sees the reset-time request
    property p_latch_delay;
        $past(rst_n) |-> instr_burst_req_latched == $past(instr_burst_req);
    endproperty
    a_latch_delay: assert property (p_latch_delay)
        else $error("latched burst request is not the request one cycle late");

    property p_first_access;
        instr_req |=> !instr_ready [*2] ##1 instr_ready;
    endproperty
    a_first_access: assert property (p_first_access)
        else $error("first instruction not delivered on the third cycle");

    property p_burst_ready;
        instr_burst_ack |-> instr_ready;
    endproperty
    a_burst_ready: assert property (p_burst_ready)
        else $error("burst acknowledge without an instruction");

    property p_burst_cause;
        $rose(instr_burst_ack) |-> $past(instr_burst_req_latched);
    endproperty
    a_burst_cause: assert property (p_burst_cause)
        else $error("burst entered without latched burst request");

    property p_data_ok;
        data_req && !bus_invalid && !data_space_type_hi && !data_space_type_lo
            |-> ##2 data_ready && !data_error;
    endproperty
    a_data_ok: assert property (p_data_ok)
        else $error("memory access not answered with ready after two cycles");

    property p_data_err;
        data_req && !bus_invalid && !data_space_type_hi && data_space_type_lo
            |-> ##2 data_error && !data_ready;
    endproperty
    a_data_err: assert property (p_data_err)
        else $error("io space access not answered with error");

    property p_coproc;
        data_req && data_space_type_hi |=> (!data_ready && !data_error) [*2];
    endproperty
    a_coproc: assert property (p_coproc)
        else $error("coprocessor space access was answered");

    property p_invalid;
        data_req && bus_invalid |=> (!data_ready && !data_error) [*2];
    endproperty
    a_invalid: assert property (p_invalid)
        else $error("cancelled data access was answered");

    property p_resp_cause;
        data_ready || data_error |-> $past(data_req, 2) && !$past(bus_invalid, 2);
    endproperty
    a_resp_cause: assert property (p_resp_cause)
        else $error("data answer without a valid request two cycles before");
endmodule

//--- verification/testbench.sv
// Self-checking bench joining processor end and memory controller
`timescale 1ns/10ps
module testbench;
    import isac_pkg::*;
    logic        mclk;
    logic        rst_n;
    logic [6:0]  even_bank_addr;
    logic [6:0]  odd_bank_addr;
    logic        even_bank_oe;
    logic        odd_bank_oe;
    logic [29:0] data_mem_addr;
    logic [3:0]  data_mem_we;
    logic [31:0] data_mem_wdata;
    logic        coproc_present;
    logic        fetch_start;
    logic [31:0] fetch_addr;
    logic        fetch_burst;
    logic        fetch_valid;
    logic [31:0] fetch_data;
    logic        dreq_start;
    logic [31:0] dreq_addr;
    logic [1:0]  dreq_space;
    logic [2:0]  dreq_size;
    logic        dreq_write;
    logic [31:0] dreq_wdata;
    logic        dreq_invalid;
    logic        dresp_valid;
    logic        dresp_error;
    logic [31:0] dresp_rdata;
    int          bad_count;
    int          check_count;
    int          seed;
    logic [31:0] r;

    isac_if bus_if ();

    function automatic logic [31:0] mem_word(input logic [7:0] i);
        return {~i, 8'h5A, i, i ^ 8'h3C};
    endfunction
    function automatic logic [31:0] dmem_word(input logic [29:0] w);
        return {w[7:0], 8'hD7, ~w[15:8], w[7:0]};
    endfunction
    function automatic logic [31:0] lane_mask(input logic [3:0] l);
        return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
    endfunction
    function automatic logic [3:0] exp_lanes(input logic [2:0] sz, input logic [1:0] a);
        if (sz == 3'h1) return 4'h1 << a;
        if (sz == 3'h2) return a[1] ? 4'hC : 4'h3;
        return 4'hF;
    endfunction
    function automatic logic [31:0] exp_rep(input logic [2:0] sz, input logic [31:0] wd);
        if (sz == 3'h1) return {4{wd[7:0]}};
        if (sz == 3'h2) return {2{wd[15:0]}};
        return wd;
    endfunction

    // Bank models answer from the bank address alone, so a wrong bank shows in the data
    isac_mem_ctrl u_isac_mem_ctrl (
        .mclk           (mclk),
        .rst_n          (rst_n),
        .bus            (bus_if),
        .even_bank_addr (even_bank_addr),
        .odd_bank_addr  (odd_bank_addr),
        .even_bank_oe   (even_bank_oe),
        .odd_bank_oe    (odd_bank_oe),
        .even_bank_rdata(mem_word({even_bank_addr, 1'b0})),
        .odd_bank_rdata (mem_word({odd_bank_addr, 1'b1})),
        .data_mem_addr  (data_mem_addr),
        .data_mem_we    (data_mem_we),
        .data_mem_wdata (data_mem_wdata),
        .data_mem_rdata (dmem_word(data_mem_addr)),
        .coproc_present (coproc_present)
    );
    isac_proc_end u_isac_proc_end (
        .mclk(mclk), .rst_n(rst_n), .bus(bus_if),
        .fetch_start(fetch_start), .fetch_addr(fetch_addr), .fetch_burst(fetch_burst),
        .fetch_valid(fetch_valid), .fetch_data(fetch_data),
        .dreq_start(dreq_start), .dreq_addr(dreq_addr), .dreq_space(dreq_space),
        .dreq_size(dreq_size), .dreq_write(dreq_write), .dreq_wdata(dreq_wdata),
        .dreq_invalid(dreq_invalid), .dresp_valid(dresp_valid),
        .dresp_error(dresp_error), .dresp_rdata(dresp_rdata)
    );
    isac_monitor u_isac_monitor (
        .mclk(mclk), .rst_n(rst_n), .instr_req(bus_if.instr_req),
        .instr_burst_req(bus_if.instr_burst_req),
        .instr_burst_req_latched(bus_if.instr_burst_req_latched),
        .instr_burst_ack(bus_if.instr_burst_ack), .instr_ready(bus_if.instr_ready),
        .data_req(bus_if.data_req), .data_space_type_lo(bus_if.data_space_type_lo),
        .data_space_type_hi(bus_if.data_space_type_hi), .bus_invalid(bus_if.bus_invalid),
        .data_ready(bus_if.data_ready), .data_error(bus_if.data_error)
    );

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Burst request drops only after n words, so extra words may still follow on
    task automatic fetch(input logic [31:0] a, input logic b, input int n);
        int         got;
        logic [7:0] idx;
        got = 0;
        idx = a[9:2];
        @(posedge mclk);
        fetch_start <= 1'b1;
        fetch_addr <= a;
        fetch_burst <= b;
        @(posedge mclk);
        fetch_start <= 1'b0;
        for (int i = 0; i < 40; i++) begin
            @(negedge mclk);
            if (even_bank_oe === 1'b1 && odd_bank_oe === 1'b1) chk("bank_oe", 0, 1);
            if (fetch_valid === 1'b1) begin
                chk("fetch_data", mem_word(idx), fetch_data);
                idx++;
                got++;
                if (got == n) begin
                    @(posedge mclk);
                    fetch_burst <= 1'b0;
                end
            end
        end
        if (!b) chk("single_count", 1, got);
        else if (got < n) chk("burst_count", n, got);
    endtask

    task automatic daccess(input logic [31:0] a, input logic [1:0] sp, input logic [2:0] sz,
                           input logic wr, input logic [31:0] wd, input logic inv);
        logic        ok;
        logic        er;
        logic [3:0]  ln;
        logic [31:0] rep;
        int          seen;
        int          wseen;
        ok = !inv && sp == 2'h0;
        er = !inv && sp == 2'h1;
        ln = exp_lanes(sz, a[1:0]);
        rep = exp_rep(sz, wd);
        seen = 0;
        wseen = 0;
        @(posedge mclk);
        dreq_start <= 1'b1;
        dreq_addr <= a;
        dreq_space <= sp;
        dreq_size <= sz;
        dreq_write <= wr;
        dreq_wdata <= wd;
        dreq_invalid <= inv;
        @(posedge mclk);
        dreq_start <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            @(negedge mclk);
            if (data_mem_we !== 4'h0) begin
                wseen++;
                chk("data_mem_we", {28'h0, ln}, {28'h0, data_mem_we});
                chk("data_mem_addr", {2'h0, a[31:2]}, {2'h0, data_mem_addr});
                chk("data_mem_wdata", rep & lane_mask(ln), data_mem_wdata & lane_mask(ln));
            end
            if (dresp_valid === 1'b1 || dresp_error === 1'b1) begin
                seen++;
                chk("dresp_error", {31'h0, er}, {31'h0, dresp_error});
                if (ok && !wr) chk("dresp_rdata", dmem_word(a[31:2]), dresp_rdata);
            end
        end
        chk("response_count", (ok || er) ? 1 : 0, seen);
        chk("write_count", (ok && wr) ? 1 : 0, wseen);
    endtask

    initial begin
        bad_count = 0;
        check_count = 0;
        seed = 32'h8D15F8CB;
        rst_n = 1'b0;
        coproc_present = 1'b0;
        fetch_start = 1'b0;
        fetch_addr = 32'h0;
        fetch_burst = 1'b0;
        dreq_start = 1'b0;
        dreq_addr = 32'h0;
        dreq_space = 2'h0;
        dreq_size = 3'h0;
        dreq_write = 1'b0;
        dreq_wdata = 32'h0;
        dreq_invalid = 1'b0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        fetch(32'h0000_0100, 1'b1, 6);
        fetch(32'h0000_0104, 1'b1, 5);
        fetch(32'h8000_03F8, 1'b1, 4);
        fetch(32'h0000_020C, 1'b0, 1);
        for (int k = 0; k < 10; k++) begin
            r = $random(seed);
            fetch(r, r[0], 2 + r[3:1]);
        end
        // Every space type against every access size, lanes walking with k
        for (int k = 0; k < 12; k++) begin
            daccess(32'h40 + k, 2'(k / 3), 3'(k % 3), 1'b1, 32'hA1B2C3D4, 1'b0);
        end
        daccess(32'h0000_0082, 2'h0, 3'h1, 1'b1, 32'h0000_00E7, 1'b1);
        @(posedge mclk);
        coproc_present <= 1'b1;
        for (int k = 0; k < 40; k++) begin
            r = $random(seed);
            daccess(r, r[5:4], 3'(r[7:6] % 3), r[8], $random(seed), r[11:9] == 3'h0);
        end
        give_verdict();
    end
endmodule
